// ### src/cml_fetch_dec.sv
// Combinational decode of the on-chip code limit from the size field.
// Also qualifies a raw size field for the top module, through size_legal.
`timescale 1ns/100ps
`default_nettype none
module cml_fetch_dec (
  input  wire logic [2:0]  size_sel,
  input  wire logic [15:0] addr,
  output logic             in_range,
  output logic             size_legal
);
  logic [15:0] limit;
  logic        zero_kb;
  always_comb begin
    limit   = 16'h0000;
    zero_kb = 1'b0;
    unique case (size_sel)
      3'h0: zero_kb = 1'b1;
      3'h1: limit = 16'h03ff;
      3'h2: limit = 16'h07ff;
      3'h3: limit = 16'h0fff;
      3'h4: limit = 16'h1fff;
      3'h5: limit = cml_pkg::FLASH_TOP;
      default: zero_kb = 1'b1;
    endcase
  end
  assign in_range   = !zero_kb && (addr <= limit);
  assign size_legal = (size_sel <= cml_pkg::SIZE_RESET);
endmodule
`default_nettype wire

// ### src/cml_pkg.sv
// Constants, types and field layouts of the code map and lock block.
// Assumes a 200 MHz system clock and a synchronous active-high reset.
//
// What this block does
// - Two 8KB flash blocks form one 16KB code range from 0000h to 3FFFh.
// - Latched external-access pin low sends every fetch to the external bus.
// - External-access pin is sampled on every exit from reset.
// - Fetches above the selected on-chip limit go to the external bus.
// - Size field codes 000..101 give 0,1,2,4,8,16KB; 110 and 111 reserved.
// - Size field resets to the 16KB setting.
// - Size register write accepted only right after key bytes AAh then 55h.
// - A new size takes effect at once, on the very next fetch.
// - With 0KB selected, vector fetches in the lowest 1KB go external.
// - Once security array is non-erased, verify bytes are XNOR with array.
// - Lock byte sits at array offset 40h; lock bits three,two,one at 5,4,3.
// - Programmed lock bits persist; only mass erase clears them.
// - Level 2: no table reads of internal code from external code.
// - Level 3 adds no verify and no internal SRAM data moves from external.
// - Level 4 adds a ban on executing code from external memory.
// - Lock bits restrict loader and parallel access, not in-application.
// - Option byte bit 3 set disables the watchdog reset at power-up.
// - Undefined option bits read as 1; option byte readable at FCh.
package cml_pkg;
  localparam logic [7:0]  REG_SIZE_SEL    = 8'hc2;
  localparam logic [7:0]  REG_TA_KEY      = 8'hc7;
  localparam logic [7:0]  REG_OPTION      = 8'hfc;
  localparam logic [7:0]  TA_KEY_FIRST    = 8'haa;
  localparam logic [7:0]  TA_KEY_SECOND   = 8'h55;
  localparam logic [2:0]  SIZE_RESET      = 3'h5;
  localparam logic [15:0] FLASH_TOP       = 16'h3fff;
  localparam logic [15:0] VECTOR_TOP      = 16'h03ff;
  localparam logic [5:0]  LOCK_BYTE_ADDR  = 6'h00;
  localparam logic [6:0]  LOCK_BYTE_OFS   = 7'h40;
  localparam int          LOCK_BIT_THREE  = 5;
  localparam int          LOCK_BIT_TWO    = 4;
  localparam int          LOCK_BIT_ONE    = 3;
  localparam int          OPT_WDT_BIT     = 3;
  localparam logic [7:0]  OPT_UNDEF_ONES  = 8'hf7;
  localparam logic [7:0]  ERASED_BYTE     = 8'hff;
  localparam int          SEC_DEPTH       = 64;
  localparam int          SEC_AW          = 6;
  typedef enum logic [1:0] {
    CML_TA_IDLE,
    CML_TA_HALF,
    CML_TA_OPEN
  } cml_ta_state_t;
  typedef enum logic [1:0] {
    CML_PM_APP,
    CML_PM_LOADER,
    CML_PM_PARALLEL
  } cml_prog_mode_t;
endpackage

// ### src/cml_sec_mem.sv
// Security array: 64 bytes of encryption data plus a lock byte.
// Assumes writes come only from the programming path of the top module.
`timescale 1ns/100ps
`default_nettype none
module cml_sec_mem (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       erase,
  input  wire logic       wr_en,
  input  wire logic [5:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       lock_wr,
  input  wire logic [7:0] lock_data,
  input  wire logic [5:0] rd_addr,
  output logic      [7:0] rd_data_q,
  output logic      [7:0] lock_q,
  output logic            programmed_q
);
  logic [7:0] mem [cml_pkg::SEC_DEPTH];
  logic [cml_pkg::SEC_DEPTH-1:0] used;

  // Flash cells only clear bits; erase is the only way back to FFh.
  genvar g;
  for (g = 0; g < cml_pkg::SEC_DEPTH; g++) begin : g_cell
    always_ff @(posedge clk) begin
      if (erase) begin
        mem[g] <= cml_pkg::ERASED_BYTE;
      end else if (wr_en && wr_addr == 6'(g)) begin
        mem[g] <= mem[g] & wr_data;
      end
    end
    assign used[g] = (mem[g] != cml_pkg::ERASED_BYTE);
  end

  always_ff @(posedge clk) begin
    if (erase) begin
      lock_q <= cml_pkg::ERASED_BYTE;
    end else if (lock_wr) begin
      lock_q <= lock_q & lock_data;
    end
  end

  always_ff @(posedge clk) begin
    rd_data_q    <= mem[rd_addr];
    programmed_q <= |used;
  end
endmodule
`default_nettype wire

// ### src/cml_top.sv
// Code memory map, timed access, lock levels and option byte.
// Assumes fetch, register and programming strobes are synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module cml_top (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ext_access_pin,
  input  wire logic       fetch_req,
  input  wire logic [15:0] fetch_addr,
  input  wire logic       fetch_from_ext,
  input  wire logic       table_read,
  input  wire logic       data_move_int,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic [1:0] prog_mode,
  input  wire logic       mass_erase,
  input  wire logic       sec_wr,
  input  wire logic [6:0] sec_addr,
  input  wire logic [7:0] sec_wdata,
  input  wire logic       opt_wr,
  input  wire logic [7:0] opt_wdata,
  input  wire logic       verify_req,
  input  wire logic [7:0] verify_code,
  input  wire logic [5:0] verify_key_addr,
  input  wire logic       pm_flash_req,
  output logic            fetch_valid_q,
  output logic            fetch_internal_q,
  output logic            fetch_external_q,
  output logic            fetch_denied_q,
  output logic            table_block_q,
  output logic            data_move_block_q,
  output logic [7:0]      sfr_rdata_q,
  output logic            verify_valid_q,
  output logic [7:0]      verify_data_q,
  output logic            verify_denied_q,
  output logic            pm_flash_grant_q,
  output logic            ea_latched_q,
  output logic [2:0]      code_limit_field_q,
  output logic            watchdog_reset_enable_q
);
  ////////////////////////////////////////////////////////////////////////
  // Reset exit pin capture and timed access.
  logic                   rst_d1_q;
  logic                   ea_pin_q;
  cml_pkg::cml_ta_state_t ta_q;
  cml_pkg::cml_ta_state_t ta_d;
  logic [2:0]             size_q;
  logic [2:0]             size_d;
  logic                   reset_exit;
  logic                   wr_ta;
  logic                   wr_size;
  logic                   size_ok;

  assign reset_exit = rst_d1_q && !rst;
  assign wr_ta   = sfr_wr && (sfr_addr == cml_pkg::REG_TA_KEY);
  assign wr_size = sfr_wr && (sfr_addr == cml_pkg::REG_SIZE_SEL);

  always_ff @(posedge clk) begin
    rst_d1_q <= rst;
  end

  always_ff @(posedge clk) begin
    if (reset_exit) begin
      ea_pin_q <= ext_access_pin;
    end
  end

  always_comb begin
    ta_d = cml_pkg::CML_TA_IDLE;
    unique case (ta_q)
      cml_pkg::CML_TA_IDLE:
        if (wr_ta && sfr_wdata == cml_pkg::TA_KEY_FIRST) begin
          ta_d = cml_pkg::CML_TA_HALF;
        end
      cml_pkg::CML_TA_HALF:
        if (wr_ta && sfr_wdata == cml_pkg::TA_KEY_SECOND) begin
          ta_d = cml_pkg::CML_TA_OPEN;
        end
      cml_pkg::CML_TA_OPEN:
        ta_d = cml_pkg::CML_TA_IDLE;
      default:
        ta_d = cml_pkg::CML_TA_IDLE;
    endcase
  end

  // A reserved code is refused and the old size is kept.
  assign size_d = (wr_size && ta_q == cml_pkg::CML_TA_OPEN && size_ok)
                  ? sfr_wdata[2:0] : size_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      ta_q   <= cml_pkg::CML_TA_IDLE;
      size_q <= cml_pkg::SIZE_RESET;
    end else begin
      ta_q   <= ta_d;
      size_q <= size_d;
    end
  end

  cml_fetch_dec u_chk (
    .size_sel   (sfr_wdata[2:0]),
    .addr       (16'h0000),
    .in_range   (),
    .size_legal (size_ok)
  );

  ////////////////////////////////////////////////////////////////////////
  // Fetch steering, using the live size so a change applies at once.
  logic in_range;
  logic lvl2;
  logic lvl3;
  logic lvl4;
  logic go_int;
  logic [7:0] lock_byte;

  cml_fetch_dec u_dec (
    .size_sel   (size_q),
    .addr       (fetch_addr),
    .in_range   (in_range),
    .size_legal ()
  );

  assign lvl4 = !lock_byte[cml_pkg::LOCK_BIT_THREE];
  assign lvl3 = lvl4 || !lock_byte[cml_pkg::LOCK_BIT_TWO];
  assign lvl2 = lvl3 || !lock_byte[cml_pkg::LOCK_BIT_ONE];
  assign go_int = ea_pin_q && in_range;

  always_ff @(posedge clk) begin
    if (rst) begin
      fetch_valid_q     <= 1'b0;
      fetch_internal_q  <= 1'b0;
      fetch_external_q  <= 1'b0;
      fetch_denied_q    <= 1'b0;
      table_block_q     <= 1'b0;
      data_move_block_q <= 1'b0;
    end else begin
      fetch_valid_q     <= fetch_req;
      fetch_internal_q  <= fetch_req && go_int;
      fetch_external_q  <= fetch_req && !go_int && !lvl4;
      fetch_denied_q    <= fetch_req && !go_int && lvl4;
      table_block_q     <= table_read && fetch_from_ext && lvl2;
      data_move_block_q <= data_move_int && fetch_from_ext && lvl3;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Security array, lock byte and option byte.
  logic       prog_access;
  logic       lock_sel;
  logic [7:0] key_byte;
  logic       sec_used;
  logic       verify_pend_q;
  logic [7:0] code_hold_q;
  logic [7:0] opt_q;
  logic       prog_blocked;

  assign prog_blocked = (prog_mode != cml_pkg::CML_PM_APP) && lvl2;
  assign prog_access = sec_wr && !prog_blocked;
  assign lock_sel = (sec_addr == cml_pkg::LOCK_BYTE_OFS);

  cml_sec_mem u_sec (
    .clk          (clk),
    .rst          (rst),
    .erase        (mass_erase),
    .wr_en        (prog_access && !sec_addr[6]),
    .wr_addr      (sec_addr[5:0]),
    .wr_data      (sec_wdata),
    .lock_wr      (prog_access && lock_sel),
    .lock_data    (sec_wdata),
    .rd_addr      (verify_key_addr),
    .rd_data_q    (key_byte),
    .lock_q       (lock_byte),
    .programmed_q (sec_used)
  );

  always_ff @(posedge clk) begin
    if (mass_erase) begin
      opt_q <= cml_pkg::ERASED_BYTE;
    end else if (opt_wr && !prog_blocked) begin
      opt_q <= opt_q & opt_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      verify_pend_q   <= 1'b0;
      code_hold_q     <= 8'h00;
      verify_valid_q  <= 1'b0;
      verify_data_q   <= 8'h00;
      verify_denied_q <= 1'b0;
    end else begin
      verify_pend_q   <= verify_req && !lvl3;
      code_hold_q     <= verify_code;
      verify_valid_q  <= verify_pend_q;
      verify_denied_q <= verify_req && lvl3;
      if (verify_pend_q) begin
        verify_data_q <= sec_used ? ~(code_hold_q ^ key_byte)
                                  : code_hold_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register reads and status outputs.
  logic [7:0] rd_mux;
  logic [7:0] opt_view;
  assign opt_view = opt_q | cml_pkg::OPT_UNDEF_ONES;
  assign rd_mux = (sfr_addr == cml_pkg::REG_SIZE_SEL) ? {5'h00, size_q}
                : (sfr_addr == cml_pkg::REG_OPTION)   ? opt_view
                : 8'h00;

  always_ff @(posedge clk) begin
    if (rst) begin
      sfr_rdata_q             <= 8'h00;
      pm_flash_grant_q        <= 1'b0;
      ea_latched_q            <= 1'b0;
      code_limit_field_q      <= cml_pkg::SIZE_RESET;
      watchdog_reset_enable_q <= 1'b0;
    end else begin
      sfr_rdata_q        <= sfr_rd ? rd_mux : 8'h00;
      pm_flash_grant_q   <= pm_flash_req && !prog_blocked;
      ea_latched_q       <= ea_pin_q;
      code_limit_field_q <= size_q;
      watchdog_reset_enable_q <= !opt_q[cml_pkg::OPT_WDT_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  chk_pin_low_ext: assert property (@(posedge clk) disable iff (rst)
    fetch_req && !ea_pin_q |=> !fetch_internal_q)
    else $error("Fetch went internal with pin low.");
  chk_ta_gate: assert property (@(posedge clk) disable iff (rst)
    wr_size && ta_q != cml_pkg::CML_TA_OPEN |=> $stable(size_q))
    else $error("Size changed without key sequence.");
  chk_size_reset: assert property (@(posedge clk)
    rst |=> size_q == cml_pkg::SIZE_RESET)
    else $error("Size did not reset to 16KB.");
  chk_limit_ext: assert property (@(posedge clk) disable iff (rst)
    fetch_req && fetch_addr > cml_pkg::FLASH_TOP |=> !fetch_internal_q)
    else $error("Fetch above 16KB went internal.");
  chk_zero_vec: assert property (@(posedge clk) disable iff (rst)
    fetch_req && size_q == 3'h0 && fetch_addr <= cml_pkg::VECTOR_TOP
    |=> !fetch_internal_q)
    else $error("Vector fetch stayed internal at 0KB.");
  chk_lvl4_exec: assert property (@(posedge clk) disable iff (rst)
    fetch_req && lvl4 |=> !fetch_external_q)
    else $error("External execution at level 4.");
  chk_verify_ban: assert property (@(posedge clk) disable iff (rst)
    verify_req && lvl3 |=> ##1 !verify_valid_q)
    else $error("Verify answered at level 3.");
  chk_table_block: assert property (@(posedge clk) disable iff (rst)
    table_read && fetch_from_ext && lvl2 |=> table_block_q)
    else $error("Table read not blocked at level 2.");
  chk_wdt_erase: assert property (@(posedge clk) disable iff (rst)
    mass_erase |=> ##1 !watchdog_reset_enable_q)
    else $error("Watchdog enabled after option erase.");
  chk_wdt_enable: assert property (@(posedge clk) disable iff (rst)
    opt_wr && !opt_wdata[cml_pkg::OPT_WDT_BIT] && !prog_blocked
    && !mass_erase |=> ##1 watchdog_reset_enable_q)
    else $error("Watchdog not enabled by cleared option bit.");

  // Size register and pin: keyed writes land, reserved codes do not, 55h after AAh opens the window, pin latches on reset exit.
  chk_size_accept: assert property (@(posedge clk) disable iff (rst)
    wr_size && ta_q == cml_pkg::CML_TA_OPEN && sfr_wdata[7:3] == 5'h00
    && sfr_wdata[2:0] <= cml_pkg::SIZE_RESET
    |=> {5'h00, size_q} == $past(sfr_wdata))
    else $error("Keyed size write did not land.");
  chk_size_reserved: assert property (@(posedge clk) disable iff (rst)
    wr_size && sfr_wdata[2:0] > cml_pkg::SIZE_RESET |=> $stable(size_q))
    else $error("Reserved size code was taken.");
  chk_ta_order: assert property (@(posedge clk) disable iff (rst)
    ta_q == cml_pkg::CML_TA_HALF && wr_ta
    && sfr_wdata == cml_pkg::TA_KEY_SECOND |=> ta_q == cml_pkg::CML_TA_OPEN)
    else $error("Second key byte did not open the window.");
  chk_pin_latch: assert property (@(posedge clk) disable iff (rst)
    reset_exit |=> ea_pin_q == $past(ext_access_pin))
    else $error("Pin not latched on reset exit.");

  // Fetch steering: one target per fetch, internal inside the mapped range.
  chk_one_target: assert property (@(posedge clk) disable iff (rst)
    fetch_valid_q |-> $onehot({fetch_internal_q, fetch_external_q,
                               fetch_denied_q}))
    else $error("Fetch answer not exactly one target.");
  chk_int_fetch: assert property (@(posedge clk) disable iff (rst)
    fetch_req && ea_pin_q && size_q == cml_pkg::SIZE_RESET
    && fetch_addr <= cml_pkg::FLASH_TOP |=> fetch_internal_q)
    else $error("Fetch inside 16KB did not go internal.");
  chk_vec_int: assert property (@(posedge clk) disable iff (rst)
    fetch_req && ea_pin_q && size_q == 3'h1
    && fetch_addr <= cml_pkg::VECTOR_TOP |=> fetch_internal_q)
    else $error("Fetch inside 1KB did not go internal.");

  // Lock levels against verify, data moves, table reads and loader access.
  chk_verify_lat: assert property (@(posedge clk) disable iff (rst)
    verify_req && !lvl3 |=> ##1 verify_valid_q)
    else $error("Verify not answered below level 3.");
  chk_data_block: assert property (@(posedge clk) disable iff (rst)
    data_move_int && fetch_from_ext && lvl3 |=> data_move_block_q)
    else $error("Data move not blocked at level 3.");
  chk_data_free: assert property (@(posedge clk) disable iff (rst)
    data_move_int && !fetch_from_ext |=> !data_move_block_q)
    else $error("Data move from internal code blocked.");
  chk_table_int: assert property (@(posedge clk) disable iff (rst)
    table_read && !fetch_from_ext |=> !table_block_q)
    else $error("Table read from internal code blocked.");
  chk_loader_block: assert property (@(posedge clk) disable iff (rst)
    pm_flash_req && prog_mode != cml_pkg::CML_PM_APP && lvl2
    |=> !pm_flash_grant_q)
    else $error("Loader access granted while locked.");
  chk_app_grant: assert property (@(posedge clk) disable iff (rst)
    pm_flash_req && prog_mode == cml_pkg::CML_PM_APP |=> pm_flash_grant_q)
    else $error("In-application access refused.");
  chk_lock_persist: assert property (@(posedge clk) disable iff (rst)
    !mass_erase |=> (lock_byte & ~$past(lock_byte)) == 8'h00)
    else $error("Lock bit came back without erase.");
  chk_opt_read: assert property (@(posedge clk) disable iff (rst)
    sfr_rd && sfr_addr == cml_pkg::REG_OPTION
    |=> (sfr_rdata_q & cml_pkg::OPT_UNDEF_ONES) == cml_pkg::OPT_UNDEF_ONES)
    else $error("Undefined option bits did not read as one.");

  cov_size_change: cover property (@(posedge clk) wr_size
    && ta_q == cml_pkg::CML_TA_OPEN);
  cov_ext_fetch: cover property (@(posedge clk) fetch_external_q);
  cov_enc_verify: cover property (@(posedge clk) verify_valid_q && sec_used);
  cov_lvl4_deny: cover property (@(posedge clk) fetch_denied_q);
  cov_zero_kb: cover property (@(posedge clk) fetch_req && size_q == 3'h0);
endmodule
`default_nettype wire

// ### verification/cml_ext_mem.sv
// Model of the external program memory on the expanded bus.
// Assumes the external fetch strobe is a one-cycle pulse on clk.
`timescale 1ns/100ps
`default_nettype none
module cml_ext_mem (
  input  wire logic        clk,
  input  wire logic        ext_fetch,
  output logic      [15:0] hits
);
  // Counts fetches served off chip so the bench can balance its tally.
  initial hits = 16'h0000;
  always @(posedge clk) begin
    if (ext_fetch === 1'b1) begin
      hits <= hits + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ### verification/code_memory_map_and_lock_test.sv
// Self-checking bench of the code map and lock block.
// Assumes the design and package files are compiled first.
`timescale 1ns/100ps
`default_nettype none
module code_memory_map_and_lock_test;
  localparam logic [2:0] INT = 3'h4;
  localparam logic [2:0] EXT = 3'h2;
  localparam logic [2:0] DEN = 3'h1;
  logic clk = '0, rst = '1, pin = '1, fetch_req = '0, from_ext = '0;
  logic tbl = '0, dmv = '0, sfr_wr = '0, sfr_rd = '0, erase = '0;
  logic sec_wr = '0, opt_wr = '0, ver_req = '0, pm_req = '0;
  logic [15:0] faddr = '0;
  logic [7:0]  sfr_addr = '0, sfr_wdata = '0, sec_wdata = '0;
  logic [7:0]  opt_wdata = '0, vcode = '0, rd_s, v;
  logic [6:0]  sec_addr = '0;
  logic [5:0]  vkey = '0;
  logic [1:0]  pmode = '0;
  logic fv, fi, fe, fd, tb_q, dm_q, vv, vden, grant, ea, wdt;
  logic [7:0]  rdata, vdata;
  logic [2:0]  lim_f;
  logic [15:0] hits, a;
  logic [3:0]  snap;
  logic [2:0]  fq[$];
  logic [7:0]  vq[$];
  logic [31:0] seed = 32'h0000297d;
  logic [15:0] lim [6] = '{16'h0000, 16'h03ff, 16'h07ff, 16'h0fff,
                           16'h1fff, 16'h3fff};
  int err_total = 0;
  int n_checks = 0;
  int n_ext = 0;

  always #2.5 clk = ~clk;

  cml_top cml_top_inst (
    .clk(clk), .rst(rst), .ext_access_pin(pin), .fetch_req(fetch_req),
    .fetch_addr(faddr), .fetch_from_ext(from_ext), .table_read(tbl),
    .data_move_int(dmv), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .prog_mode(pmode),
    .mass_erase(erase), .sec_wr(sec_wr), .sec_addr(sec_addr),
    .sec_wdata(sec_wdata), .opt_wr(opt_wr), .opt_wdata(opt_wdata),
    .verify_req(ver_req), .verify_code(vcode), .verify_key_addr(vkey),
    .pm_flash_req(pm_req), .fetch_valid_q(fv), .fetch_internal_q(fi),
    .fetch_external_q(fe), .fetch_denied_q(fd), .table_block_q(tb_q),
    .data_move_block_q(dm_q), .sfr_rdata_q(rdata), .verify_valid_q(vv),
    .verify_data_q(vdata), .verify_denied_q(vden),
    .pm_flash_grant_q(grant), .ea_latched_q(ea),
    .code_limit_field_q(lim_f), .watchdog_reset_enable_q(wdt)
  );

  cml_ext_mem cml_ext_mem_inst (.clk(clk), .ext_fetch(fe), .hits(hits));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // One request cycle, then a quiet cycle so no strobe toggles twice.
  task automatic op();
    @(posedge clk);
    #1;
    {fetch_req, tbl, dmv, sfr_wr, sfr_rd, erase} = '0;
    {sec_wr, opt_wr, ver_req, pm_req} = '0;
    snap = {tb_q, dm_q, vden, grant};
    rd_s = rdata;
    @(posedge clk);
    #1;
  endtask

  task automatic fetch(input logic [15:0] ad, input logic [2:0] e);
    faddr = ad;
    fetch_req = 1'b1;
    fq.push_back(e);
    if (e == EXT) n_ext++;
    op();
  endtask

  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    sfr_addr = ad;
    sfr_rd = 1'b1;
    op();
    chk(rd_s, e);
  endtask

  task automatic key(input logic [2:0] c, input logic gap);
    // No fetch overlaps the map change, as if interrupts were off and the
    // code ran from a side that the change leaves alone.
    fetch_req = 1'b0;
    sfr_wr = 1'b1;
    sfr_addr = cml_pkg::REG_TA_KEY;
    sfr_wdata = cml_pkg::TA_KEY_FIRST;
    @(posedge clk);
    #1 sfr_wdata = cml_pkg::TA_KEY_SECOND;
    @(posedge clk);
    #1;
    if (gap) begin
      sfr_wr = 1'b0;
      @(posedge clk);
      #1 sfr_wr = 1'b1;
    end
    sfr_addr = cml_pkg::REG_SIZE_SEL;
    sfr_wdata = {5'h00, c};
    @(posedge clk);
    #1 sfr_wr = 1'b0;
    // Two idle machine cycles before code jumps into the new range.
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic sec(input logic [6:0] ad, input logic [7:0] d);
    sec_addr = ad;
    sec_wdata = d;
    sec_wr = 1'b1;
    op();
  endtask

  task automatic ver(input logic [7:0] c, input logic [7:0] e);
    vcode = c;
    vkey = 6'h05;
    ver_req = 1'b1;
    vq.push_back(e);
    op();
  endtask

  task automatic reset(input logic p);
    rst = 1'b1;
    pin = p;
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({7'h00, ea}, {7'h00, p});
  endtask

  ////////////////////////////////////////////////////////////////////////
  always @(negedge clk) begin
    if (fv === 1'b1) chk({5'h00, fi, fe, fd}, {5'h00, fq.pop_front()});
    if (vv === 1'b1) chk(vdata, vq.pop_front());
  end

  initial begin
    #40000;
    err_total++;
    finish_test();
  end

  initial begin
    // Flash state has no reset, so erase it while the core is held.
    erase = 1'b1;
    @(posedge clk);
    #1 erase = 1'b0;
    reset(1'b1);
    erase = 1'b1;
    op();
    chk({5'h00, lim_f}, 8'h05);
    chk({7'h00, wdt}, 8'h00);
    rd(cml_pkg::REG_OPTION, 8'hff);
    fetch(16'h0000, INT);
    fetch(16'h3fff, INT);
    fetch(16'h4000, EXT);
    pin = 1'b0;
    fetch(16'h0100, INT);
    repeat (16) begin
      a = 16'(xs() >> 8);
      fetch(a, (a <= 16'h3fff) ? INT : EXT);
    end
    sfr_addr = cml_pkg::REG_SIZE_SEL;
    sfr_wdata = 8'h03;
    sfr_wr = 1'b1;
    op();
    chk({5'h00, lim_f}, 8'h05);
    key(3'h3, 1'b1);
    fetch(16'h3fff, INT);
    key(3'h6, 1'b0);
    rd(cml_pkg::REG_SIZE_SEL, 8'h05);
    chk({5'h00, lim_f}, 8'h05);
    // Sweep every legal size, probing the first fetch after each change.
    for (int c = 0; c < 6; c++) begin
      key(c[2:0], 1'b0);
      fetch(c == 0 ? 16'h03ff : lim[c], c == 0 ? EXT : INT);
      fetch(lim[c] + 16'h0001, EXT);
      chk({5'h00, lim_f}, c[7:0]);
    end
    opt_wdata = 8'h00;
    opt_wr = 1'b1;
    op();
    chk({7'h00, wdt}, 8'h01);
    rd(cml_pkg::REG_OPTION, 8'hf7);
    v = 8'(xs());
    ver(v, v);
    sec(7'h05, 8'h3c);
    repeat (4) begin
      v = 8'(xs());
      ver(v, ~(v ^ 8'h3c));
    end
    sec(7'h40, 8'hf7);
    from_ext = 1'b1;
    tbl = 1'b1;
    op();
    chk({7'h00, snap[3]}, 8'h01);
    from_ext = 1'b0;
    tbl = 1'b1;
    op();
    chk({7'h00, snap[3]}, 8'h00);
    pmode = cml_pkg::CML_PM_LOADER;
    pm_req = 1'b1;
    op();
    chk({7'h00, snap[0]}, 8'h00);
    sec(7'h40, 8'hc7);
    pmode = cml_pkg::CML_PM_APP;
    pm_req = 1'b1;
    op();
    chk({7'h00, snap[0]}, 8'h01);
    ver(8'h11, ~(8'h11 ^ 8'h3c));
    sec(7'h40, 8'he7);
    ver_req = 1'b1;
    op();
    chk({7'h00, snap[1]}, 8'h01);
    from_ext = 1'b1;
    dmv = 1'b1;
    op();
    chk({7'h00, snap[2]}, 8'h01);
    from_ext = 1'b0;
    dmv = 1'b1;
    op();
    chk({7'h00, snap[2]}, 8'h00);
    from_ext = 1'b1;
    sec(7'h40, 8'hc7);
    fetch(16'h4000, DEN);
    fetch(16'h0000, INT);
    sec(7'h40, 8'hff);
    fetch(16'h4000, DEN);
    erase = 1'b1;
    op();
    fetch(16'h4000, EXT);
    from_ext = 1'b0;
    reset(1'b0);
    fetch(16'h0000, EXT);
    fetch(16'h3fff, EXT);
    chk(hits[7:0], n_ext[7:0]);
    chk(8'(fq.size()), 8'h00);
    chk(8'(vq.size()), 8'h00);
    finish_test();
  end
endmodule
`default_nettype wire
